// ### rtl/qlc_pkg.sv
// constants shared by the dual quadrature counter
package qlc_pkg;
    // ****************************************************************
    // bus map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] GCTRL_ADDR = 8'h00;
    localparam logic [7:0] INST0_BASE = 8'h20;
    localparam logic [7:0] INST1_BASE = 8'h40;
    localparam logic [7:0] INST_SPAN = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_LOWER = 8'h08;
    localparam logic [7:0] OFS_PRESET = 8'h0c;
    localparam logic [7:0] OFS_VALUE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int GCTRL_RUN_BIT = 0;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int CTRL_PLD_BIT = 2;
    localparam int CTRL_RET_BIT = 3;
    localparam int STAT_UP_BIT = 0;
    localparam int STAT_LO_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;
    localparam int STAT_OVF_BIT = 3;
    // ****************************************************************
    // reset values and limits
    // ****************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] VAL_MAX = 32'h7fff_ffff;
    localparam logic [31:0] VAL_MIN = 32'h8000_0000;
    localparam logic [31:0] STEP_ONE = 32'h0000_0001;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### rtl/qlc_top.sv
// dual quadrature counter with limit flags and ahb-lite register slave
//
// Added by the designer: register access over AHB-Lite and the register addresses.

module qlc_top (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [3:0] din_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [1:0] upper_limit_flag_o,
    output logic [1:0] lower_limit_flag_o,
    output logic [1:0] zero_value_flag_o,
    output logic [1:0] range_overflow_flag_o,
    output logic [31:0] actual_value0_o,
    output logic [31:0] actual_value1_o
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic run;
        logic [1:0] en;
        logic [1:0] clr;
        logic [1:0] pld;
        logic [1:0] pld_prev;
        logic [1:0] ret;
        logic [1:0][31:0] upper;
        logic [1:0][31:0] lower;
        logic [1:0][31:0] preset;
        logic [1:0][31:0] val;
        logic [1:0] f_up;
        logic [1:0] f_lo;
        logic [1:0] f_zero;
        logic [1:0] f_ovf;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } qlc_state_t;

    qlc_state_t q;
    qlc_state_t n;
    logic [1:0] step_up;
    logic [1:0] step_dn;
    logic [1:0] active;
    logic [1:0] pld_edge;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // quadrature step: 2'b01 up, 2'b10 down, 2'b00 none or illegal jump
    function automatic logic [1:0] qlc_step(input logic a_old, input logic b_old,
                                            input logic a_new, input logic b_new);
        logic a_chg;
        logic b_chg;
        a_chg = a_old ^ a_new;
        b_chg = b_old ^ b_new;
        qlc_step = 2'h0;
        if (a_chg && !b_chg) begin
            qlc_step = (a_new != b_new) ? 2'h1 : 2'h2;
        end else if (b_chg && !a_chg) begin
            qlc_step = (b_new == a_new) ? 2'h1 : 2'h2;
        end
    endfunction

    // returns {upper, lower, zero} for a value against its setpoints
    function automatic logic [2:0] qlc_flags(input logic [31:0] v, input logic [31:0] up,
                                             input logic [31:0] lo);
        qlc_flags = {($signed(v) >= $signed(up)), ($signed(v) <= $signed(lo)), (v == qlc_pkg::RST_WORD)};
    endfunction

    // instance index of an address, 2'h3 when outside both windows
    function automatic logic [1:0] qlc_inst(input logic [7:0] a);
        if (a >= qlc_pkg::INST0_BASE && a < qlc_pkg::INST0_BASE + qlc_pkg::INST_SPAN) begin
            qlc_inst = 2'h0;
        end else if (a >= qlc_pkg::INST1_BASE && a < qlc_pkg::INST1_BASE + qlc_pkg::INST_SPAN) begin
            qlc_inst = 2'h1;
        end else begin
            qlc_inst = 2'h3;
        end
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [1:0] st;
        logic [1:0] wi;
        logic [1:0] ri;
        logic [7:0] wofs;
        logic [7:0] rofs;
        logic [2:0] fl;
        logic start;
        logic [1:0] recalc;
        logic [7:0] a;
        st = 2'h0;
        wi = 2'h3;
        ri = 2'h3;
        wofs = 8'h00;
        rofs = 8'h00;
        fl = 3'h0;
        start = 1'b0;
        recalc = 2'h0;
        a = haddr_i[7:0];
        n = q;
        step_up = 2'h0;
        step_dn = 2'h0;
        active = 2'h0;
        pld_edge = 2'h0;

        // two-stage synchroniser on the phase pins
        n.sync1 = din_i;
        n.sync2 = q.sync1;
        n.prev = q.sync2;

        // bus data phase: write uses the captured address
        if (q.ap_valid && q.ap_write) begin
            wi = qlc_inst(q.ap_addr);
            if (q.ap_addr == qlc_pkg::GCTRL_ADDR) begin
                n.run = hwdata_i[qlc_pkg::GCTRL_RUN_BIT];
                start = hwdata_i[qlc_pkg::GCTRL_RUN_BIT] && !q.run;
            end else if (wi != 2'h3) begin
                wofs = q.ap_addr - ((wi == 2'h0) ? qlc_pkg::INST0_BASE : qlc_pkg::INST1_BASE);
                unique case (wofs)
                    qlc_pkg::OFS_CTRL: begin
                        n.en[wi[0]] = hwdata_i[qlc_pkg::CTRL_EN_BIT];
                        n.clr[wi[0]] = hwdata_i[qlc_pkg::CTRL_CLR_BIT];
                        n.pld[wi[0]] = hwdata_i[qlc_pkg::CTRL_PLD_BIT];
                        n.ret[wi[0]] = hwdata_i[qlc_pkg::CTRL_RET_BIT];
                    end
                    qlc_pkg::OFS_UPPER: begin
                        n.upper[wi[0]] = hwdata_i;
                    end
                    qlc_pkg::OFS_LOWER: begin
                        n.lower[wi[0]] = hwdata_i;
                    end
                    qlc_pkg::OFS_PRESET: begin
                        n.preset[wi[0]] = hwdata_i;
                    end
                    qlc_pkg::OFS_VALUE: begin
                        // saved value is restored by software only while stopped
                        if (!q.run) begin
                            n.val[wi[0]] = hwdata_i;
                            recalc[wi[0]] = 1'b1;
                        end
                    end
                    qlc_pkg::OFS_STATUS: begin
                        if (hwdata_i[qlc_pkg::STAT_OVF_BIT]) begin
                            n.f_ovf[wi[0]] = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // counting, one instance per phase pair
        for (int i = 0; i < 2; i++) begin
            st = qlc_step(q.prev[2*i], q.prev[2*i+1], q.sync2[2*i], q.sync2[2*i+1]);
            step_up[i] = st[0];
            step_dn[i] = st[1];
            active[i] = q.run && q.en[i];
            pld_edge[i] = q.pld[i] && !q.pld_prev[i];
            n.pld_prev[i] = q.pld[i];
            if (start && !q.ret[i]) begin
                n.val[i] = qlc_pkg::RST_WORD;
                recalc[i] = 1'b1;
            end else if (active[i]) begin
                recalc[i] = 1'b1;
                if (q.clr[i]) begin
                    n.val[i] = qlc_pkg::RST_WORD;
                    n.f_ovf[i] = 1'b0;
                end else if (pld_edge[i]) begin
                    n.val[i] = n.preset[i];
                    n.f_ovf[i] = 1'b0;
                end else if (step_up[i]) begin
                    n.val[i] = 32'(q.val[i] + qlc_pkg::STEP_ONE);
                    if (q.val[i] == qlc_pkg::VAL_MAX) begin
                        n.f_ovf[i] = 1'b1;
                    end
                end else if (step_dn[i]) begin
                    n.val[i] = 32'(q.val[i] - qlc_pkg::STEP_ONE);
                    if (q.val[i] == qlc_pkg::VAL_MIN) begin
                        n.f_ovf[i] = 1'b1;
                    end
                end
            end
            if (recalc[i]) begin
                fl = qlc_flags(n.val[i], n.upper[i], n.lower[i]);
                n.f_up[i] = fl[2];
                n.f_lo[i] = fl[1];
                n.f_zero[i] = fl[0];
            end
        end

        // bus address phase: read data taken from post-update state
        n.ready = 1'b1;
        n.resp = 1'b0;
        n.ap_valid = hsel_i && hready_i && (htrans_i == qlc_pkg::HTRANS_NONSEQ);
        n.ap_write = hwrite_i;
        n.ap_addr = a;
        n.rdata = qlc_pkg::RST_WORD;
        if (n.ap_valid && !hwrite_i) begin
            ri = qlc_inst(a);
            if (a == qlc_pkg::GCTRL_ADDR) begin
                n.rdata[qlc_pkg::GCTRL_RUN_BIT] = n.run;
            end else if (ri != 2'h3) begin
                rofs = a - ((ri == 2'h0) ? qlc_pkg::INST0_BASE : qlc_pkg::INST1_BASE);
                unique case (rofs)
                    qlc_pkg::OFS_CTRL: begin
                        n.rdata[qlc_pkg::CTRL_EN_BIT] = n.en[ri[0]];
                        n.rdata[qlc_pkg::CTRL_CLR_BIT] = n.clr[ri[0]];
                        n.rdata[qlc_pkg::CTRL_PLD_BIT] = n.pld[ri[0]];
                        n.rdata[qlc_pkg::CTRL_RET_BIT] = n.ret[ri[0]];
                    end
                    qlc_pkg::OFS_UPPER: begin
                        n.rdata = n.upper[ri[0]];
                    end
                    qlc_pkg::OFS_LOWER: begin
                        n.rdata = n.lower[ri[0]];
                    end
                    qlc_pkg::OFS_PRESET: begin
                        n.rdata = n.preset[ri[0]];
                    end
                    qlc_pkg::OFS_VALUE: begin
                        n.rdata = n.val[ri[0]];
                    end
                    qlc_pkg::OFS_STATUS: begin
                        n.rdata[qlc_pkg::STAT_UP_BIT] = n.f_up[ri[0]];
                        n.rdata[qlc_pkg::STAT_LO_BIT] = n.f_lo[ri[0]];
                        n.rdata[qlc_pkg::STAT_ZERO_BIT] = n.f_zero[ri[0]];
                        n.rdata[qlc_pkg::STAT_OVF_BIT] = n.f_ovf[ri[0]];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.f_up <= 2'h3;
            q.f_lo <= 2'h3;
            q.f_zero <= 2'h3;
        end else begin
            q <= n;
        end
    end

    assign hrdata_o = q.rdata;
    assign hreadyout_o = q.ready;
    assign hresp_o = q.resp;
    assign upper_limit_flag_o = q.f_up;
    assign lower_limit_flag_o = q.f_lo;
    assign zero_value_flag_o = q.f_zero;
    assign range_overflow_flag_o = q.f_ovf;
    assign actual_value0_o = q.val[0];
    assign actual_value1_o = q.val[1];

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // flags follow the value
    a_upper_flag_ge: assert property ($past(active[0]) |->
        q.f_up[0] == ($signed(q.val[0]) >= $signed(q.upper[0])))
        else $error("upper flag disagrees with value");
    a_upper_flag_one: assert property ($past(active[1]) |->
        q.f_up[1] == ($signed(q.val[1]) >= $signed(q.upper[1])))
        else $error("upper flag of second counter disagrees");
    a_lower_flag_le: assert property ($past(active[1]) |->
        q.f_lo[1] == ($signed(q.val[1]) <= $signed(q.lower[1])))
        else $error("lower flag disagrees with value");
    a_lower_flag_first: assert property ($past(active[0]) |->
        q.f_lo[0] == ($signed(q.val[0]) <= $signed(q.lower[0])))
        else $error("lower flag of first counter disagrees");
    a_zero_flag_eq: assert property ($past(active[0]) |->
        q.f_zero[0] == (q.val[0] == qlc_pkg::RST_WORD))
        else $error("zero flag disagrees with value");
    a_zero_flag_one: assert property ($past(active[1]) |->
        q.f_zero[1] == (q.val[1] == qlc_pkg::RST_WORD))
        else $error("zero flag of second counter disagrees");

    // wrap and overflow
    a_wrap_sets_ovf: assert property (active[0] && !q.clr[0] && !pld_edge[0] && step_up[0]
        && q.val[0] == qlc_pkg::VAL_MAX |=> q.f_ovf[0] && q.val[0] == qlc_pkg::VAL_MIN
        && !q.f_up[0] == ($signed(q.upper[0]) > $signed(q.val[0])))
        else $error("wrap did not raise overflow");
    a_wrap_down_ovf: assert property (active[0] && !q.clr[0] && !pld_edge[0] && step_dn[0]
        && q.val[0] == qlc_pkg::VAL_MIN |=> q.f_ovf[0] && q.val[0] == qlc_pkg::VAL_MAX)
        else $error("down wrap did not raise overflow");

    // coils
    a_clear_to_zero: assert property (active[0] && q.clr[0] |=> q.val[0] == qlc_pkg::RST_WORD && q.f_zero[0])
        else $error("clear did not zero the value");
    a_preset_loads: assert property (active[0] && !q.clr[0] && pld_edge[0] |=> q.val[0] == $past(n.preset[0]))
        else $error("preset not loaded on coil edge");
    a_disabled_holds: assert property (q.run && !q.en[0] |=> $stable(q.val[0]) && $stable(q.f_up[0]))
        else $error("value moved while disabled");
    a_disabled_one: assert property (q.run && !q.en[1] |=> $stable(q.val[1]) && $stable(q.f_lo[1]))
        else $error("second value moved while disabled");

    // counting
    a_step_up_one: assert property (active[0] && !q.clr[0] && !pld_edge[0] && step_up[0] |=>
        q.val[0] == 32'($past(q.val[0]) + qlc_pkg::STEP_ONE))
        else $error("up step not counted by one");
    a_step_down_one: assert property (active[1] && !q.clr[1] && !pld_edge[1] && step_dn[1] |=>
        q.val[1] == 32'($past(q.val[1]) - qlc_pkg::STEP_ONE))
        else $error("down step not counted by one");
    a_pin_to_count: assert property (active[0] && !q.clr[0] && !pld_edge[0] && $changed(q.sync2[0])
        && $stable(q.sync2[1]) |=> q.val[0] != $past(q.val[0]))
        else $error("phase edge was not counted");

    // run mode and retention
    a_stop_no_clear: assert property (!q.run && q.clr[0] && !(q.ap_valid && q.ap_write) |=>
        $stable(q.val[0]))
        else $error("value cleared outside run mode");
    a_retain_keeps: assert property (q.ap_valid && q.ap_write && q.ap_addr == qlc_pkg::GCTRL_ADDR
        && hwdata_i[qlc_pkg::GCTRL_RUN_BIT] && !q.run && q.ret[0]
        |=> $stable(q.val[0]))
        else $error("retentive value lost at start");
    a_start_zeroes: assert property (q.ap_valid && q.ap_write && q.ap_addr == qlc_pkg::GCTRL_ADDR
        && hwdata_i[qlc_pkg::GCTRL_RUN_BIT] && !q.run && !q.ret[1]
        |=> q.val[1] == qlc_pkg::RST_WORD)
        else $error("non-retentive value kept at start");

    c_wrap_up: cover property (active[0] && step_up[0] && q.val[0] == qlc_pkg::VAL_MAX);
    c_count_down: cover property (active[1] && step_dn[1]);
    c_preset_edge: cover property (active[0] && pld_edge[0]);
    c_clear_run: cover property (active[0] && q.clr[0] ##1 q.f_zero[0]);
    c_retain_start: cover property (q.ap_valid && q.ap_write && q.ap_addr == qlc_pkg::GCTRL_ADDR && !q.run && q.ret[0]);
endmodule // qlc_top

// ### test/qlc_encoder.sv
// behavioural incremental encoder driving both phase pairs
module qlc_encoder #(
    parameter int QSTEP = 4167
) (
    input wire logic sys_clk_i,
    input wire logic start_i,
    input wire logic inst_i,
    input wire logic up_i,
    input wire logic [7:0] edges_i,
    output logic busy_o,
    output logic [3:0] din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // phase state
    // ****************************************************************
    logic [1:0] ph0 = 2'h0;
    logic [1:0] ph1 = 2'h0;
    logic sel = 1'b0;
    logic dir = 1'b0;
    int left = 0;
    int tick = 0;
    logic busy = 1'b0;
    assign busy_o = busy;
    // gray sequence: one phase changes per step, a quarter period apart
    assign din_o = {ph1[1], ^ph1, ph0[1], ^ph0};
    // ****************************************************************
    // edge generator
    // ****************************************************************
    // evenly spaced edges give equal high and low times
    // default spacing keeps a quarter period at the slowest rate limit
    always @(posedge sys_clk_i) begin
        if (!busy && start_i) begin
            busy <= 1'b1;
            left <= int'(edges_i);
            tick <= 0;
            sel <= inst_i;
            dir <= up_i;
        end else if (busy) begin
            if (left == 0) begin
                busy <= 1'b0;
            end else if (tick == QSTEP - 1) begin
                tick <= 0;
                left <= left - 1;
                if (sel) begin
                    ph1 <= ph1 + (dir ? 2'h1 : 2'h3);
                end else begin
                    ph0 <= ph0 + (dir ? 2'h1 : 2'h3);
                end
            end else begin
                tick <= tick + 1;
            end
        end
    end
endmodule // qlc_encoder

// ### test/test_qlc_top.sv
// self-checking bench for the dual quadrature counter
module test_qlc_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals
    // ****************************************************************
    localparam logic [7:0] B0 = qlc_pkg::INST0_BASE;
    localparam logic [7:0] B1 = qlc_pkg::INST1_BASE;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [1:0] upper_limit_flag_o;
    logic [1:0] lower_limit_flag_o;
    logic [1:0] zero_value_flag_o;
    logic [1:0] range_overflow_flag_o;
    logic [31:0] actual_value0_o;
    logic [31:0] actual_value1_o;
    logic [3:0] din;
    logic enc_start = 1'b0;
    logic enc_inst = 1'b0;
    logic enc_up = 1'b0;
    logic enc_busy;
    logic [7:0] enc_edges = 8'h00;
    logic [31:0] rd;
    int n_mismatch = 0;
    int check_count = 0;
    qlc_top qlc_top_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .din_i(din), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .upper_limit_flag_o(upper_limit_flag_o), .lower_limit_flag_o(lower_limit_flag_o),
        .zero_value_flag_o(zero_value_flag_o), .range_overflow_flag_o(range_overflow_flag_o),
        .actual_value0_o(actual_value0_o), .actual_value1_o(actual_value1_o));
    qlc_encoder #(.QSTEP(6)) qlc_encoder_i (.sys_clk_i(sys_clk_i), .start_i(enc_start), .inst_i(enc_inst),
        .up_i(enc_up), .edges_i(enc_edges), .busy_o(enc_busy), .din_o(din));
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 100);
        if (hreadyout_o !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH t=%0t bus never ready", $time);
            results();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h00_0000, a};
        htrans_i <= qlc_pkg::HTRANS_NONSEQ;
        hwrite_i <= w;
        wait_rdy();
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        wait_rdy();
        rd = hrdata_o;
        chk({31'h0, hresp_o}, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic move(input logic k, input logic up, input logic [7:0] e);
        int n;
        @(posedge sys_clk_i);
        enc_start <= 1'b1;
        enc_inst <= k;
        enc_up <= up;
        enc_edges <= e;
        @(posedge sys_clk_i);
        enc_start <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (enc_busy !== 1'b0 && n < 2000);
        if (enc_busy !== 1'b0) begin
            n_mismatch++;
            $display("MISMATCH t=%0t encoder stuck", $time);
            results();
        end
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic flags(input logic k, input logic [31:0] v, input logic [31:0] hi, input logic [31:0] lo);
        chk(k ? actual_value1_o : actual_value0_o, v);
        chk({29'h0, upper_limit_flag_o[k], lower_limit_flag_o[k], zero_value_flag_o[k]},
            {29'h0, $signed(v) >= $signed(hi), $signed(v) <= $signed(lo), v == 32'h0000_0000});
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic s_count;
        wr(qlc_pkg::GCTRL_ADDR, 32'h0000_0001);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0001);
        move(1'b0, 1'b1, 8'h08);
        chk(actual_value0_o, 32'h0000_0008);
        move(1'b1, 1'b1, 8'h04);
        chk(actual_value1_o, 32'h0000_0000);
        wr(B1 + qlc_pkg::OFS_CTRL, 32'h0000_0001);
        move(1'b1, 1'b0, 8'h05);
        chk(actual_value1_o, 32'hffff_fffb);
        chk(actual_value0_o, 32'h0000_0008);
        flags(1'b1, 32'hffff_fffb, 32'h0000_0000, 32'h0000_0000);
        chk({30'h0, range_overflow_flag_o}, 32'h0000_0000);
        rdc(B1 + qlc_pkg::OFS_VALUE, 32'hffff_fffb);
    endtask
    task automatic s_flags;
        wr(B0 + qlc_pkg::OFS_UPPER, 32'h0000_000a);
        wr(B0 + qlc_pkg::OFS_LOWER, 32'h0000_0003);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0003);
        flags(1'b0, 32'h0000_0000, 32'h0000_000a, 32'h0000_0003);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0001);
        move(1'b0, 1'b1, 8'h03);
        flags(1'b0, 32'h0000_0003, 32'h0000_000a, 32'h0000_0003);
        move(1'b0, 1'b1, 8'h01);
        flags(1'b0, 32'h0000_0004, 32'h0000_000a, 32'h0000_0003);
        move(1'b0, 1'b1, 8'h06);
        flags(1'b0, 32'h0000_000a, 32'h0000_000a, 32'h0000_0003);
        move(1'b0, 1'b0, 8'h01);
        flags(1'b0, 32'h0000_0009, 32'h0000_000a, 32'h0000_0003);
    endtask
    task automatic s_over;
        wr(B0 + qlc_pkg::OFS_PRESET, 32'h7fff_fffe);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0005);
        flags(1'b0, 32'h7fff_fffe, 32'h0000_000a, 32'h0000_0003);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0001);
        move(1'b0, 1'b1, 8'h03);
        flags(1'b0, 32'h8000_0001, 32'h0000_000a, 32'h0000_0003);
        rdc(B0 + qlc_pkg::OFS_STATUS, 32'h0000_000a);
        wr(B0 + qlc_pkg::OFS_STATUS, 32'h0000_0008);
        chk({31'h0, range_overflow_flag_o[0]}, 32'h0000_0000);
        wr(B0 + qlc_pkg::OFS_PRESET, qlc_pkg::VAL_MIN);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0005);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0001);
        move(1'b0, 1'b0, 8'h01);
        flags(1'b0, qlc_pkg::VAL_MAX, 32'h0000_000a, 32'h0000_0003);
        chk({31'h0, range_overflow_flag_o[0]}, 32'h0000_0001);
    endtask
    task automatic s_retain;
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0009);
        wr(qlc_pkg::GCTRL_ADDR, 32'h0000_0000);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_000b);
        chk(actual_value0_o, qlc_pkg::VAL_MAX);
        wr(B0 + qlc_pkg::OFS_CTRL, 32'h0000_0009);
        wr(B0 + qlc_pkg::OFS_VALUE, 32'h0000_0100);
        rdc(B0 + qlc_pkg::OFS_VALUE, 32'h0000_0100);
        wr(qlc_pkg::GCTRL_ADDR, 32'h0000_0001);
        chk(actual_value0_o, 32'h0000_0100);
        chk(actual_value1_o, 32'h0000_0000);
        move(1'b0, 1'b1, 8'h02);
        chk(actual_value0_o, 32'h0000_0102);
        wr(B0 + qlc_pkg::OFS_VALUE, 32'h0000_0005);
        chk(actual_value0_o, 32'h0000_0102);
        rdc(8'hfc, 32'h0000_0000);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        s_count();
        s_flags();
        s_over();
        s_retain();
        results();
    end
endmodule // test_qlc_top
